// *** pkg/ccp_pkg.sv ***
package ccp_pkg;
    // control styles
    localparam logic [1:0] STYLE_BUS = 2'h0;
    localparam logic [1:0] STYLE_I2C = 2'h1;
    localparam logic [1:0] STYLE_STRAP = 2'h2;
    // audio formats from strap pins
    localparam logic [1:0] FMT_I2S = 2'h0;
    localparam logic [1:0] FMT_LSB16 = 2'h1;
    localparam logic [1:0] FMT_LSB20 = 2'h2;
    localparam logic [1:0] FMT_LSB24 = 2'h3;
    // address byte fields
    localparam int TYPE_LSB = 0;
    localparam int TYPE_MSB = 1;
    localparam int DEVADR_LSB = 2;
    localparam int DEVADR_MSB = 7;
    localparam logic [4:0] DEVADR_FIXED = 5'h02;
    localparam logic [1:0] TYPE_WRITE = 2'h2;
    localparam logic [1:0] TYPE_READ = 2'h3;
    // byte sizes
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [1:0] BYTE_LAST = 2'h3;
    // register address byte flag position
    localparam int RW_FLAG = 0;
    localparam int REG_ADR_BITS = 7;
endpackage

// *** hw/ccp_edge_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccp_edge_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // pin
    input wire logic pin_in,
    // synced level and edges
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // ----------------------------------------
    // two-stage synchroniser, then edge detect
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            // bus lines idle high, so no false edge after reset
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            last_ff <= 1'b1;
        end
        else if (clk_en_in)
        begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level_out = sync_ff;
    assign rise_out = clk_en_in & sync_ff & ~last_ff;
    assign fall_out = clk_en_in & ~sync_ff & last_ff;
endmodule // ccp_edge_sync
`default_nettype wire

// *** hw/ccp_ctrl_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccp_ctrl_port (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // pins
    input wire logic style_pin_in,
    input wire logic ctl_clock_pin_in,
    input wire logic ctl_phase_pin_in,
    input wire logic ctl_data_pin_in,
    output logic ctl_data_pin_out,
    output logic ctl_data_pin_oe_out,
    input wire logic fast_silence_pin_in,
    input wire logic input_choice_pin_in,
    // strap results
    output logic [1:0] style_out,
    output logic clock_384_out,
    output logic [1:0] audio_format_out,
    output logic input_two_out,
    // register side
    output logic wr_valid_out,
    output logic [6:0] wr_addr_out,
    output logic [15:0] wr_data_out,
    output logic rd_req_out,
    output logic [6:0] rd_addr_out,
    input wire logic rd_addr_valid_in,
    input wire logic [15:0] rd_data_in
);
    typedef enum logic [3:0] {
        CCP_IDLE = 4'h1,
        CCP_WRITE = 4'h2,
        CCP_READ = 4'h4,
        CCP_DESEL = 4'h8
    } ccp_state_type;

    logic clk_lvl;
    logic clk_rise;
    logic clk_fall;
    logic phase_lvl;
    logic phase_rise;
    logic phase_fall;
    logic data_lvl;
    logic sel_ip_lvl;
    logic [3:0] pin_meta_ff;
    logic [3:0] pin_sync_ff;
    ccp_state_type state_ff;
    logic [2:0] bit_cnt_ff;
    logic [1:0] byte_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] nxt_byte;
    logic byte_done;
    logic bus_mode;
    logic [6:0] reg_addr_ff;
    logic [7:0] high_data_byte_ff;
    logic [23:0] tx_ff;
    logic [1:0] transfer_type_bits;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    ccp_edge_sync u_clk_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .pin_in(ctl_clock_pin_in),
        .level_out(clk_lvl),
        .rise_out(clk_rise),
        .fall_out(clk_fall)
    );

    ccp_edge_sync u_phase_sync (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .pin_in(ctl_phase_pin_in),
        .level_out(phase_lvl),
        .rise_out(phase_rise),
        .fall_out(phase_fall)
    );

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
        end
        else if (clk_en_in)
        begin
            pin_meta_ff <= {style_pin_in, ctl_data_pin_in, fast_silence_pin_in, input_choice_pin_in};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign data_lvl = pin_sync_ff[2];
    assign sel_ip_lvl = pin_sync_ff[0];

    // ----------------------------------------
    // style and strap decode
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            style_out <= ccp_pkg::STYLE_BUS;
            clock_384_out <= 1'b0;
            audio_format_out <= ccp_pkg::FMT_I2S;
            input_two_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (!pin_sync_ff[3])
                style_out <= ccp_pkg::STYLE_BUS;
            else if (!phase_lvl)
                style_out <= ccp_pkg::STYLE_I2C;
            else
                style_out <= ccp_pkg::STYLE_STRAP;
            if (pin_sync_ff[3] && phase_lvl)
            begin
                clock_384_out <= clk_lvl;
                audio_format_out <= {data_lvl, pin_sync_ff[1]};
                input_two_out <= sel_ip_lvl;
            end
        end
    end

    assign bus_mode = ~pin_sync_ff[3];

    // ----------------------------------------
    // bit and byte counting, LSB first
    // ----------------------------------------
    assign nxt_byte = {data_lvl, shift_ff[7:1]};
    assign byte_done = bus_mode & clk_rise & (bit_cnt_ff == ccp_pkg::BIT_LAST);

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            bit_cnt_ff <= 3'h0;
            byte_cnt_ff <= 2'h0;
            shift_ff <= 8'h00;
        end
        else if (clk_en_in)
        begin
            if (phase_rise || phase_fall || !bus_mode)
            begin
                bit_cnt_ff <= 3'h0;
                byte_cnt_ff <= 2'h0;
            end
            else if (clk_rise)
            begin
                shift_ff <= nxt_byte;
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                if (byte_done && byte_cnt_ff != ccp_pkg::BYTE_LAST)
                    byte_cnt_ff <= byte_cnt_ff + 2'h1;
            end
        end
    end

    assign transfer_type_bits = {nxt_byte[ccp_pkg::TYPE_MSB], nxt_byte[ccp_pkg::TYPE_LSB]};

    // ----------------------------------------
    // transfer state machine
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_ff <= CCP_IDLE;
            reg_addr_ff <= 7'h00;
            rd_addr_out <= 7'h00;
            high_data_byte_ff <= 8'h00;
            wr_valid_out <= 1'b0;
            wr_addr_out <= 7'h00;
            wr_data_out <= 16'h0000;
            rd_req_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            wr_valid_out <= 1'b0;
            rd_req_out <= 1'b0;
            if (byte_done && !phase_lvl)
            begin
                if (nxt_byte[ccp_pkg::DEVADR_MSB:ccp_pkg::DEVADR_LSB + 1] != ccp_pkg::DEVADR_FIXED
                    || nxt_byte[ccp_pkg::DEVADR_LSB] != sel_ip_lvl)
                    state_ff <= CCP_DESEL;
                else if (transfer_type_bits == ccp_pkg::TYPE_WRITE)
                    state_ff <= CCP_WRITE;
                else if (transfer_type_bits == ccp_pkg::TYPE_READ)
                begin
                    state_ff <= CCP_READ;
                    rd_req_out <= 1'b1;
                end
                else
                    state_ff <= CCP_DESEL;
            end
            else if (byte_done)
            begin
                case (state_ff)
                    CCP_WRITE:
                    begin
                        case (byte_cnt_ff)
                            2'h0:
                            begin
                                reg_addr_ff <= {nxt_byte[1], nxt_byte[2], nxt_byte[3], nxt_byte[4],
                                                nxt_byte[5], nxt_byte[6], nxt_byte[7]};
                                if (nxt_byte[ccp_pkg::RW_FLAG])
                                begin
                                    rd_addr_out <= {nxt_byte[1], nxt_byte[2], nxt_byte[3], nxt_byte[4],
                                                    nxt_byte[5], nxt_byte[6], nxt_byte[7]};
                                    state_ff <= CCP_IDLE;
                                end
                            end
                            2'h1: high_data_byte_ff <= {nxt_byte[0], nxt_byte[1], nxt_byte[2], nxt_byte[3],
                                                         nxt_byte[4], nxt_byte[5], nxt_byte[6], nxt_byte[7]};
                            2'h2:
                            begin
                                wr_valid_out <= 1'b1;
                                wr_addr_out <= reg_addr_ff;
                                wr_data_out <= {high_data_byte_ff, nxt_byte[0], nxt_byte[1], nxt_byte[2],
                                                nxt_byte[3], nxt_byte[4], nxt_byte[5], nxt_byte[6], nxt_byte[7]};
                                state_ff <= CCP_IDLE;
                            end
                            default: state_ff <= CCP_IDLE;
                        endcase
                    end
                    CCP_READ:
                        if (byte_cnt_ff == 2'h2)
                            state_ff <= CCP_IDLE;
                    CCP_DESEL: state_ff <= CCP_DESEL;
                    default: state_ff <= CCP_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // read return shifter, launched on falling edge
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            tx_ff <= 24'h000000;
            ctl_data_pin_out <= 1'b0;
            ctl_data_pin_oe_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (rd_req_out)
                // flag then A6..A0, then data MSB first per byte
                tx_ff <= {rd_data_in[0], rd_data_in[1], rd_data_in[2], rd_data_in[3],
                          rd_data_in[4], rd_data_in[5], rd_data_in[6], rd_data_in[7],
                          rd_data_in[8], rd_data_in[9], rd_data_in[10], rd_data_in[11],
                          rd_data_in[12], rd_data_in[13], rd_data_in[14], rd_data_in[15],
                          rd_addr_out[0], rd_addr_out[1], rd_addr_out[2], rd_addr_out[3],
                          rd_addr_out[4], rd_addr_out[5], rd_addr_out[6], ~rd_addr_valid_in};
            if (state_ff == CCP_READ && phase_lvl && bus_mode)
            begin
                if (clk_fall)
                begin
                    ctl_data_pin_oe_out <= 1'b1;
                    ctl_data_pin_out <= tx_ff[0];
                    tx_ff <= {1'b0, tx_ff[23:1]};
                end
            end
            else
                ctl_data_pin_oe_out <= 1'b0;
        end
    end
endmodule // ccp_ctrl_port
`default_nettype wire

// *** verif/ccp_ctrl_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccp_ctrl_port_sva (
    // clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // watched ports
    input wire logic ctl_clock_pin_in,
    input wire logic ctl_phase_pin_in,
    input wire logic ctl_data_pin_out,
    input wire logic ctl_data_pin_oe_out,
    input wire logic [1:0] style_out,
    input wire logic [1:0] audio_format_out,
    input wire logic wr_valid_out,
    input wire logic [15:0] wr_data_out,
    input wire logic rd_req_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    property p_oe_bus;
        ctl_data_pin_oe_out |-> style_out == ccp_pkg::STYLE_BUS;
    endproperty
    a_oe_bus: assert property (p_oe_bus) else $error("data driven outside bus mode");
    property p_oe_addr;
        !ctl_phase_pin_in [*8] |-> !ctl_data_pin_oe_out;
    endproperty
    a_oe_addr: assert property (p_oe_addr) else $error("data driven in address phase");
    property p_launch;
        ctl_data_pin_oe_out && $past(ctl_data_pin_oe_out) && $changed(ctl_data_pin_out) |-> !ctl_clock_pin_in;
    endproperty
    a_launch: assert property (p_launch) else $error("read bit changed while clock high");
    property p_wr_pulse;
        wr_valid_out |=> !wr_valid_out;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");
    property p_wr_when;
        wr_valid_out |-> ctl_clock_pin_in && ctl_phase_pin_in;
    endproperty
    a_wr_when: assert property (p_wr_when) else $error("write strobe outside data phase");
    property p_rd_when;
        rd_req_out |-> ctl_clock_pin_in && !ctl_phase_pin_in ##1 !rd_req_out;
    endproperty
    a_rd_when: assert property (p_rd_when) else $error("read request outside address phase");
    property p_wr_hold;
        !wr_valid_out |-> $stable(wr_data_out);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write data moved without strobe");
    property p_strap_hold;
        (style_out != ccp_pkg::STYLE_STRAP) [*3] |-> $stable(audio_format_out);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("format moved outside strap mode");
    property p_write_bus;
        wr_valid_out |-> style_out == ccp_pkg::STYLE_BUS;
    endproperty
    a_write_bus: assert property (p_write_bus) else $error("write strobe outside bus mode");
endmodule // ccp_ctrl_port_sva
bind ccp_ctrl_port ccp_ctrl_port_sva chk_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ctl_clock_pin_in(ctl_clock_pin_in),
    .ctl_phase_pin_in(ctl_phase_pin_in), .ctl_data_pin_out(ctl_data_pin_out),
    .ctl_data_pin_oe_out(ctl_data_pin_oe_out), .style_out(style_out), .audio_format_out(audio_format_out),
    .wr_valid_out(wr_valid_out), .wr_data_out(wr_data_out), .rd_req_out(rd_req_out)
);
`default_nettype wire

// *** verif/ccp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccp_host_model (
    // wire side
    output logic clk_pin_out,
    output logic phase_pin_out,
    output logic data_drv_out,
    input wire logic data_wire_in
);
    logic [23:0] rx_bits;
    initial
    begin
        clk_pin_out = 1'b1;
        phase_pin_out = 1'b1;
        data_drv_out = 1'b1;
        rx_bits = 24'h0;
    end
    // ----------------------------------------
    // one pulse: launch on fall, sample on rise
    // ----------------------------------------
    task automatic bit_cycle(input logic b, input logic rd);
        clk_pin_out = 1'b0;
        data_drv_out = rd ? ~data_drv_out : b;
        #40;
        clk_pin_out = 1'b1;
        rx_bits = {rx_bits[22:0], data_wire_in};
        #40;
    endtask
    task automatic set_pins(input logic c, input logic p, input logic d);
        clk_pin_out = c;
        phase_pin_out = p;
        data_drv_out = d;
    endtask
    task automatic wake;
        bit_cycle(1'b1, 1'b0);
        #40;
    endtask
    // vectors hold first-in-time bit at the top
    task automatic frame(input logic [7:0] adr, input logic [23:0] v, input int n, input logic rd);
        #1.3;
        phase_pin_out = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--)
            bit_cycle(adr[i], 1'b0);
        phase_pin_out = 1'b1;
        #40;
        for (int i = 23; i > 23 - n; i--)
            bit_cycle(v[i], rd);
        #80;
    endtask
    task automatic stray(input int k);
        phase_pin_out = 1'b0;
        #40;
        for (int i = 0; i < k; i++)
            bit_cycle(1'b1, 1'b0);
        phase_pin_out = 1'b1;
        #80;
    endtask
endmodule // ccp_host_model
`default_nettype wire

// *** verif/codec_control_port_and_pin_strap_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module codec_control_port_and_pin_strap_tb;
    logic clk, rst, style_pin, fsil, sel, rd_valid, hclk, hphase, hdrv, dwire, dout, doe, wr_valid, rd_req, c384, two;
    logic cken;
    logic [1:0] style, fmt;
    logic [6:0] wr_addr, rd_addr, got_addr;
    logic [15:0] wr_data, got_data, rd_data;
    // row: style pin, clock, phase, data, silence, choice | style, 384, format, channel two
    logic [11:0] rows [6] = '{12'ha20, 12'heeb, 12'hb24, 12'hfae, 12'h81e, 12'h7ce};
    int err_total, n_compared, n_wr, n_rd, base;
    ccp_ctrl_port dut_u (
        .clk_in(clk), .sys_rst_in(rst), .clk_en_in(cken), .style_pin_in(style_pin),
        .ctl_clock_pin_in(hclk), .ctl_phase_pin_in(hphase), .ctl_data_pin_in(dwire),
        .ctl_data_pin_out(dout), .ctl_data_pin_oe_out(doe), .fast_silence_pin_in(fsil),
        .input_choice_pin_in(sel), .style_out(style), .clock_384_out(c384), .audio_format_out(fmt),
        .input_two_out(two), .wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
        .rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_addr_valid_in(rd_valid), .rd_data_in(rd_data)
    );
    ccp_host_model host_u (.clk_pin_out(hclk), .phase_pin_out(hphase), .data_drv_out(hdrv), .data_wire_in(dwire));
    assign dwire = doe ? dout : hdrv;
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk)
    begin
        if (wr_valid === 1'b1)
        begin
            n_wr++;
            got_addr = wr_addr;
            got_data = wr_data;
        end
        if (rd_req === 1'b1)
            n_rd++;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic bus_write(input logic [7:0] adr, input logic [6:0] a, input logic [15:0] d, input int n);
        base = n_wr;
        host_u.frame(adr, {1'b0, a, d}, 24, 1'b0);
        check(24'(n_wr - base), 24'(n), "write count");
        if (n > 0)
            check({1'b0, got_addr, got_data}, {1'b0, a, d}, "write");
    endtask
    task automatic bus_read(input logic v, input logic [15:0] d);
        @(negedge clk);
        rd_valid = v;
        rd_data = d;
        base = n_rd;
        host_u.frame(8'he8, 24'h0, 24, 1'b1);
        check(24'(n_rd - base), 24'h1, "read count");
        check(host_u.rx_bits, {~v, 7'h2a, d}, "read return");
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_total++;
        test_done();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        cken = 1'b1;
        style_pin = 1'b1;
        fsil = 1'b0;
        sel = 1'b0;
        rd_valid = 1'b0;
        rd_data = 16'h0;
        repeat (5) @(negedge clk);
        check(24'({wr_valid, rd_req, doe, style}), 24'h0, "reset outputs");
        rst = 1'b0;
        foreach (rows[i])
        begin
            style_pin = rows[i][11];
            host_u.set_pins(rows[i][10], rows[i][9], rows[i][8]);
            fsil = rows[i][7];
            sel = rows[i][6];
            repeat (12) @(negedge clk);
            check(24'({style, c384, fmt, two}), 24'(rows[i][5:0]), "strap outputs");
        end
        host_u.set_pins(1'b1, 1'b1, 1'b1);
        sel = 1'b0;
        repeat (10) @(negedge clk);
        host_u.wake();
        bus_write(8'h48, 7'h15, 16'ha5c3, 1);
        sel = 1'b1;
        bus_write(8'h68, 7'h6a, 16'h3c5a, 1);
        bus_write(8'h48, 7'h01, 16'hffff, 0);
        bus_write(8'h28, 7'h02, 16'h1111, 0);
        bus_write(8'ha8, 7'h03, 16'h2222, 0);
        host_u.stray(3);
        bus_write(8'h68, 7'h33, 16'h0f0f, 1);
        base = n_wr;
        host_u.frame(8'h68, {1'b1, 7'h2a, 16'h0}, 8, 1'b0);
        check(24'({n_wr - base, rd_addr}), 24'h2a, "prepare read");
        bus_read(1'b1, 16'h9e61);
        bus_read(1'b0, 16'h1234);
        // frozen port ignores a whole frame, then works again
        @(negedge clk);
        cken = 1'b0;
        bus_write(8'h68, 7'h11, 16'h5555, 0);
        @(negedge clk);
        cken = 1'b1;
        bus_write(8'h68, 7'h12, 16'h6666, 1);
        test_done();
    end
endmodule // codec_control_port_and_pin_strap_tb
`default_nettype wire
